// ### verilog/usb_otg_negotiation_status.v
// Function
// - bit 19 shows b-session valid
// - bit 18 shows a-session valid
// - bit 17 shows debounce interval kind
// - bit 16 mirrors connector id pin
// - no negotiation start without device enable
// - ignore peer negotiation without host enable
// - software starts negotiation, drops after end
// - negotiation success set, cleared on request
// - software starts session request, drops after end
// - session success set, cleared on request
// - debounce finished flag in host operation
// - a-device connect wait timeout flag
// - peer negotiation detected flag
// - negotiation end flag on finish
// - session request end flag on finish
// - session end flag on vbus drop
// - device-side bits usable only in device mode
// - control register resets to 0x00000800; here it reads 0x00010800, since the id pin bit resets high
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "otg_negotiation_defines.vh"

module usb_otg_negotiation_status (
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   // axi4-lite write address
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // axi4-lite write response
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // axi4-lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // transceiver and pin levels (asynchronous)
   input  wire        b_session_threshold,
   input  wire        a_session_threshold,
   input  wire        id_pin_state,
   // controller state (same clock)
   input  wire        device_mode,
   input  wire        short_debounce,
   // protocol engine events (same clock, one-cycle pulses)
   input  wire        debounce_done,
   input  wire        a_wait_timeout,
   input  wire        peer_negotiation_request,
   input  wire        negotiation_done,
   input  wire        negotiation_ok,
   input  wire        session_request_done,
   input  wire        session_request_ok,
   // requests to protocol engine (levels)
   output wire        negotiation_start,
   output wire        session_request_start,
   output wire        peer_negotiation_accept
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
   // the pins come from analogue comparators and a connector, with no clock
   // stage 1 may go metastable, so nothing but stage 2 reads it
   // stages 2 and 3 must agree before the filtered level moves
   // a one-cycle glitch on a pin is therefore never seen by software
   // a stable change reaches the register view four edges later
   // the id chain resets high so a b-device is assumed until the pin says otherwise
   // the vbus chains reset low so no false session end follows reset

   reg  [2:0] bsv_sync_q;      // b-session valid chain
   reg  [2:0] asv_sync_q;      // a-session valid chain
   reg  [2:0] id_sync_q;       // id pin chain
   reg        bsv_q;           // filtered b-session valid
   reg        asv_q;           // filtered a-session valid
   reg        id_q;            // filtered id pin
   reg        bsv_prev_q;      // last filtered b-session valid, for fall detect

   // sample the pins and filter
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bsv_sync_q <= 3'h0;
         asv_sync_q <= 3'h0;
         id_sync_q  <= 3'h7;
         bsv_q      <= 1'b0;
         asv_q      <= 1'b0;
         id_q       <= 1'b1;
         bsv_prev_q <= 1'b0;
      end else begin
         bsv_sync_q <= {bsv_sync_q[1:0], b_session_threshold};
         asv_sync_q <= {asv_sync_q[1:0], a_session_threshold};
         id_sync_q  <= {id_sync_q[1:0], id_pin_state};
         // take a new level only once stages 2 and 3 agree
         if (bsv_sync_q[2] == bsv_sync_q[1]) begin
            bsv_q <= bsv_sync_q[2];
         end
         if (asv_sync_q[2] == asv_sync_q[1]) begin
            asv_q <= asv_sync_q[2];
         end
         if (id_sync_q[2] == id_sync_q[1]) begin
            id_q <= id_sync_q[2];
         end
         bsv_prev_q <= bsv_q;
      end
   end

   // vbus fell below the b-session threshold
   wire session_end_event = bsv_prev_q & ~bsv_q;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave handshake
   // write address and write data are taken independently, in either order
   // each half is held until the other arrives
   // the register update happens on the edge after both halves are held
   // the response is raised on that same edge and stands until bready
   // no new write half is taken while a response is pending
   // a read is answered on the same edge that takes its address
   // unmapped offsets answer slverr and leave all state alone

   reg        aw_held_q;       // write address captured
   reg        w_held_q;        // write data captured
   reg [3:0]  aw_addr_q;       // captured write address
   reg [31:0] w_data_q;        // captured write data
   reg [3:0]  w_strb_q;        // captured byte enables
   reg        bvalid_q;        // write response pending
   reg [1:0]  bresp_q;         // write response code
   reg        rvalid_q;        // read data pending
   reg [1:0]  rresp_q;         // read response code
   reg [31:0] rdata_q;         // read data

   // accept each write channel once, in either order
   assign s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign s_axi_wready  = ~w_held_q & ~bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire ar_take  = s_axi_arvalid & s_axi_arready;
   // both halves present: perform write this cycle
   wire do_write = aw_held_q & w_held_q & ~bvalid_q;

   wire wr_ctrl  = do_write & (aw_addr_q[3:2] == `OTG_CONTROL_STATUS_OFFSET >> 2);
   wire wr_flags = do_write & (aw_addr_q[3:2] == `OTG_EVENT_FLAGS_OFFSET >> 2);

   // byte-lane mask of the write
   wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   // write channel capture and response
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `AXI_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            // answer one cycle after both halves are held
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= (wr_ctrl | wr_flags) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register
   // the device-side bits take writes only while the controller is in device mode
   // the host-side enable is writable in every mode
   // a request bit drops by a zero write, or by clearing its end flag once set
   // a success bit is set by the engine outcome and cleared by a new request
   // if the outcome and a new request fall in one cycle, the outcome wins
   // software must not rely on success while the request is still up
   // all bits are plain flip-flops, so reads never see a partial update

   reg dev_neg_en_q;           // device-side negotiation enable
   reg host_neg_en_q;          // host-side negotiation enable
   reg neg_req_q;              // negotiation request
   reg neg_ok_q;               // negotiation success
   reg sess_req_q;             // session request
   reg sess_ok_q;              // session request success
   reg [31:0] flags_q;         // sticky event flags

   // field values presented by the write, per bit
   wire wb_dev_en   = w_data_q[`DEVICE_NEG_ENABLE_BIT];
   wire wb_host_en  = w_data_q[`HOST_NEG_ENABLE_BIT];
   wire wb_neg_req  = w_data_q[`NEG_REQUEST_BIT];
   wire wb_sess_req = w_data_q[`SESSION_REQUEST_BIT];
   wire wl_hi       = wr_ctrl & wmask[8];
   wire wl_lo       = wr_ctrl & wmask[0];

   // device-side bits take writes only in device mode
   wire dev_write_hi = wl_hi & device_mode;
   wire dev_write_lo = wl_lo & device_mode;

   // a rising software request clears the matching success bit
   wire neg_req_set  = dev_write_hi & wb_neg_req & ~neg_req_q;
   wire sess_req_set = dev_write_lo & wb_sess_req & ~sess_req_q;

   // software clearing an end flag also drops the request
   wire clr_neg_end  = wr_flags & wmask[8] & w_data_q[`NEG_END_BIT];
   wire clr_sess_end = wr_flags & wmask[8] & w_data_q[`SESSION_REQ_END_BIT];

   // control register update
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dev_neg_en_q  <= 1'b1;
         host_neg_en_q <= 1'b0;
         neg_req_q     <= 1'b0;
         neg_ok_q      <= 1'b0;
         sess_req_q    <= 1'b0;
         sess_ok_q     <= 1'b0;
      end else begin
         if (dev_write_hi) begin
            dev_neg_en_q <= wb_dev_en;
            neg_req_q    <= wb_neg_req;
         end else if (clr_neg_end & flags_q[`NEG_END_BIT]) begin
            neg_req_q <= 1'b0;
         end
         if (wl_hi) begin
            host_neg_en_q <= wb_host_en;
         end
         if (dev_write_lo) begin
            sess_req_q <= wb_sess_req;
         end else if (clr_sess_end & flags_q[`SESSION_REQ_END_BIT]) begin
            sess_req_q <= 1'b0;
         end
         // success: set by engine outcome, cleared on new request
         if (negotiation_done & negotiation_ok) begin
            neg_ok_q <= 1'b1;
         end else if (neg_req_set) begin
            neg_ok_q <= 1'b0;
         end
         if (session_request_done & session_request_ok) begin
            sess_ok_q <= 1'b1;
         end else if (sess_req_set) begin
            sess_ok_q <= 1'b0;
         end
      end
   end

   // negotiation starts only with device enable set, in device mode
   assign negotiation_start       = neg_req_q & dev_neg_en_q & device_mode;
   assign session_request_start   = sess_req_q & device_mode;
   // peer requests honoured only with host enable, as a-device
   assign peer_negotiation_accept = host_neg_en_q & ~id_q & ~device_mode;

   ////////////////////////////////////////////////////////////////////////////
   // sticky event flags
   // each flag is set by a one-cycle event and held until software clears it
   // clearing is by writing one to the bit; a zero write leaves it alone
   // an event in the same cycle as its clear keeps the flag set
   // so an event is never lost between a read and the clearing write
   // debounce done only counts in host operation
   // timeout and peer negotiation only count as an a-device
   // peer negotiation is further gated by the host-side enable
   // session end is the falling edge of the filtered b-session level

   reg [31:0] flag_set;        // events this cycle
   reg [31:0] flag_clr;        // software clears this cycle

   // gather events and write-one clears
   always @* begin
      flag_set = 32'h0000_0000;
      flag_set[`DEBOUNCE_FINISHED_BIT] = debounce_done & ~device_mode;
      flag_set[`A_DEVICE_TIMEOUT_BIT]  = a_wait_timeout & ~id_q;
      flag_set[`NEG_DETECTED_BIT]      = peer_negotiation_request & ~id_q & host_neg_en_q;
      flag_set[`NEG_END_BIT]           = negotiation_done;
      flag_set[`SESSION_REQ_END_BIT]   = session_request_done;
      flag_set[`SESSION_END_BIT]       = session_end_event;
      flag_clr = wr_flags ? (w_data_q & wmask) : 32'h0000_0000;
   end

   // set wins over a clear in the same cycle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flags_q <= `OTG_EVENT_FLAGS_RESET;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path
   // the control word is built live from the filtered pins, the short_debounce input and the registers
   // the pin-level bits read the same in every mode
   // reserved bits always read zero
   // read data is registered when the address is taken
   // it then stands unchanged until the master takes it
   // a state change during that wait is seen by the next read only

   reg [31:0] ctrl_view;       // assembled control/status word

   // assemble control/status word; reserved bits read zero
   always @* begin
      ctrl_view = 32'h0000_0000;
      ctrl_view[`B_SESSION_VALID_BIT]     = bsv_q;
      ctrl_view[`A_SESSION_VALID_BIT]     = asv_q;
      ctrl_view[`DEBOUNCE_INTERVAL_BIT]   = short_debounce;
      ctrl_view[`ID_PIN_STATE_BIT]        = id_q;
      ctrl_view[`DEVICE_NEG_ENABLE_BIT]   = dev_neg_en_q;
      ctrl_view[`HOST_NEG_ENABLE_BIT]     = host_neg_en_q;
      ctrl_view[`NEG_REQUEST_BIT]         = neg_req_q;
      ctrl_view[`NEG_SUCCESS_BIT]         = neg_ok_q;
      ctrl_view[`SESSION_REQUEST_BIT]     = sess_req_q;
      ctrl_view[`SESSION_REQ_SUCCESS_BIT] = sess_ok_q;
   end

   // read channel: data one cycle after address taken
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `AXI_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else begin
         if (ar_take) begin
            rvalid_q <= 1'b1;
            case (s_axi_araddr[3:2])
               2'h0: begin
                  rdata_q <= ctrl_view;
                  rresp_q <= `AXI_RESP_OKAY;
               end
               2'h1: begin
                  rdata_q <= flags_q;
                  rresp_q <= `AXI_RESP_OKAY;
               end
               default: begin
                  rdata_q <= 32'h0000_0000;
                  rresp_q <= `AXI_RESP_SLVERR;
               end
            endcase
         end else if (rvalid_q & s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // limitations
   // the negotiation and session request themselves run in the protocol engine
   // this block only holds the requests, enables, outcomes and event flags
   // the engine must pulse each done input once per finished request
   // the ok inputs are only looked at in the cycle of their done pulse
   // byte lanes are honoured; a write with no lane set changes nothing
   // there is no interrupt output; the flags are read by polling

endmodule

// ### verilog/otg_negotiation_defines.vh
`ifndef OTG_NEGOTIATION_DEFINES_VH
`define OTG_NEGOTIATION_DEFINES_VH

// register byte offsets
`define OTG_CONTROL_STATUS_OFFSET   4'h0
`define OTG_EVENT_FLAGS_OFFSET      4'h4

// reset values
`define OTG_CONTROL_STATUS_RESET    32'h0000_0800
`define OTG_EVENT_FLAGS_RESET       32'h0000_0000

// control/status field positions
`define B_SESSION_VALID_BIT         19
`define A_SESSION_VALID_BIT         18
`define DEBOUNCE_INTERVAL_BIT       17
`define ID_PIN_STATE_BIT            16
`define DEVICE_NEG_ENABLE_BIT       11
`define HOST_NEG_ENABLE_BIT         10
`define NEG_REQUEST_BIT             9
`define NEG_SUCCESS_BIT             8
`define SESSION_REQUEST_BIT         1
`define SESSION_REQ_SUCCESS_BIT     0

// event flag field positions
`define DEBOUNCE_FINISHED_BIT       19
`define A_DEVICE_TIMEOUT_BIT        18
`define NEG_DETECTED_BIT            17
`define NEG_END_BIT                 9
`define SESSION_REQ_END_BIT         8
`define SESSION_END_BIT             2

// axi4-lite responses
`define AXI_RESP_OKAY               2'h0
`define AXI_RESP_SLVERR             2'h2

`endif

// ### tb/otg_negotiation_properties.sv
`timescale 1ns/100ps
module otg_negotiation_properties (
   // clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // register bus
   input wire logic [3:0]  s_axi_araddr,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // pins and engine requests
   input wire logic        b_session_threshold,
   input wire logic        device_mode,
   input wire logic        negotiation_start,
   input wire logic        session_request_start,
   input wire logic        peer_negotiation_accept
);
   // one domain: shared clock and reset for every property
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////
   neg_mode_a : assert property (
      negotiation_start |-> device_mode) else $error("negotiation start outside device mode");
   sreq_mode_a : assert property (
      session_request_start |-> device_mode) else $error("session request outside device mode");
   peer_mode_a : assert property (
      peer_negotiation_accept |-> !device_mode) else $error("peer accept in device mode");
   neg_rise_a : assert property (
      $rose(negotiation_start) |-> s_axi_bvalid || $rose(device_mode)) else $error("negotiation start without write");
   neg_hold_a : assert property (
      $fell(negotiation_start) |-> s_axi_bvalid || !device_mode) else $error("negotiation request dropped alone");
   sreq_hold_a : assert property (
      $fell(session_request_start) |-> s_axi_bvalid || !device_mode) else $error("session request dropped alone");
   b_valid_bit_a : assert property (
      $rose(s_axi_rvalid) && $past(s_axi_araddr) == 4'h0 && $past(b_session_threshold, 2) == $past(b_session_threshold, 8)
      |-> s_axi_rdata[19] == $past(b_session_threshold, 2)) else $error("b-session bit wrong");
   unmapped_read_a : assert property (
      $rose(s_axi_rvalid) && $past(s_axi_araddr[3]) |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   bresp_hold_a : assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   rdata_hold_a : assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
bind usb_otg_negotiation_status otg_negotiation_properties u_otg_negotiation_properties (.clock, .resetn,
   .s_axi_araddr, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .b_session_threshold, .device_mode, .negotiation_start, .session_request_start,
   .peer_negotiation_accept);

// ### tb/otg_peer_model.sv
`timescale 1ns/100ps
module otg_peer_model (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // requests seen from the controller, answer control
   input  wire logic negotiation_start,
   input  wire logic session_request_start,
   input  wire logic respond,
   input  wire logic answer_ok,
   // end pulses with outcome
   output wire logic negotiation_done,
   output wire logic negotiation_ok,
   output wire logic session_request_done,
   output wire logic session_request_ok
);
   logic [2:0] neg_cnt_q;  // cycles since negotiation request
   logic [2:0] ses_cnt_q;  // cycles since session request
   logic       neg_done_q; // negotiation end pulse
   logic       ses_done_q; // session end pulse
   ////////////////////////////////////////////////////////////////////////
   // answer each request once, four cycles in, only while allowed to
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         neg_cnt_q  <= 3'h0;
         ses_cnt_q  <= 3'h0;
         neg_done_q <= 1'b0;
         ses_done_q <= 1'b0;
      end else begin
         neg_done_q <= respond && neg_cnt_q == 3'h3;
         ses_done_q <= respond && ses_cnt_q == 3'h3;
         neg_cnt_q  <= !negotiation_start ? 3'h0 : (respond && neg_cnt_q != 3'h4) ? neg_cnt_q + 3'h1 : neg_cnt_q;
         ses_cnt_q  <= !session_request_start ? 3'h0 : (respond && ses_cnt_q != 3'h4) ? ses_cnt_q + 3'h1 : ses_cnt_q;
      end
   end
   // outcome is meaningless outside the pulse, so show its inverse there
   assign negotiation_done     = neg_done_q;
   assign negotiation_ok       = neg_done_q ? answer_ok : ~answer_ok;
   assign session_request_done = ses_done_q;
   assign session_request_ok   = ses_done_q ? answer_ok : ~answer_ok;
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic        clock = 1'b0, resetn = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        b_session_threshold = 1'b0, a_session_threshold = 1'b0, id_pin_state = 1'b1;
   logic        device_mode = 1'b0, short_debounce = 1'b0, respond = 1'b0, answer_ok = 1'b0;
   logic [2:0]  host_ev = 3'h0;
   logic        negotiation_done, negotiation_ok, session_request_done, session_request_ok;
   logic        negotiation_start, session_request_start, peer_negotiation_accept;
   int          mismatches = 0, checked = 0;
   always #25 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   usb_otg_negotiation_status u_usb_otg_negotiation_status (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .b_session_threshold, .a_session_threshold, .id_pin_state, .device_mode, .short_debounce,
      .debounce_done(host_ev[0]), .a_wait_timeout(host_ev[1]), .peer_negotiation_request(host_ev[2]),
      .negotiation_done, .negotiation_ok, .session_request_done, .session_request_ok, .negotiation_start,
      .session_request_start, .peer_negotiation_accept);
   otg_peer_model u_otg_peer_model (.clock, .resetn, .negotiation_start, .session_request_start, .respond,
      .answer_ok, .negotiation_done, .negotiation_ok, .session_request_done, .session_request_ok);
   ////////////////////////////////////////////////////////////////////////
   // compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // one write: address and data offered together, response awaited
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp_resp = 2'h0);
      logic aw_t, w_t, done;
      done = 1'b0;
      @(posedge clock);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!done) begin
         @(negedge clock);
         aw_t = s_axi_awvalid & s_axi_awready;
         w_t  = s_axi_wvalid & s_axi_wready;
         done = s_axi_bvalid;
         @(posedge clock);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, exp_resp});
   endtask
   // one read, compared with the expected word and response
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] exp_resp = 2'h0);
      logic ar_t, done;
      logic [31:0] d;
      logic [1:0]  r;
      done = 1'b0;
      @(posedge clock);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!done) begin
         @(negedge clock);
         ar_t = s_axi_arvalid & s_axi_arready;
         done = s_axi_rvalid;
         d    = s_axi_rdata;
         r    = s_axi_rresp;
         @(posedge clock);
         if (ar_t) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk(d, exp);
      chk({30'h0, r}, {30'h0, exp_resp});
   endtask
   // one-cycle event pulse from the host-side engine
   task automatic pulse(input logic [2:0] k);
      @(posedge clock);
      host_ev <= k;
      @(posedge clock);
      host_ev <= 3'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_status();
      rd(4'h0, 32'h0001_0800);
      rd(4'h4, 32'h0);
      b_session_threshold <= 1'b1;
      a_session_threshold <= 1'b1;
      id_pin_state        <= 1'b0;
      short_debounce      <= 1'b1;
      repeat (8) @(posedge clock);
      rd(4'h0, 32'h000e_0800);
      b_session_threshold <= 1'b0;
      repeat (8) @(posedge clock);
      rd(4'h0, 32'h0006_0800);
      rd(4'h4, 32'h4);
      wr(4'h4, 32'h0);
      rd(4'h4, 32'h4);
      wr(4'h4, 32'h4);
      rd(4'h4, 32'h0);
      b_session_threshold <= 1'b1;
      repeat (8) @(posedge clock);
      $display("test status done");
   endtask
   task automatic t_hnp();
      device_mode <= 1'b1;
      wr(4'h0, 32'ha00);
      chk({31'h0, negotiation_start}, 32'h1);
      rd(4'h0, 32'h000e_0a00);
      respond   <= 1'b1;
      answer_ok <= 1'b1;
      repeat (8) @(posedge clock);
      rd(4'h4, 32'h200);
      rd(4'h0, 32'h000e_0b00);
      wr(4'h4, 32'h200);
      rd(4'h0, 32'h000e_0900);
      respond <= 1'b0;
      wr(4'h0, 32'h200);
      rd(4'h0, 32'h000e_0200);
      chk({31'h0, negotiation_start}, 32'h0);
      wr(4'h0, 32'h0);
      $display("test negotiation done");
   endtask
   task automatic t_srp();
      respond   <= 1'b1;
      answer_ok <= 1'b0;
      wr(4'h0, 32'h2);
      chk({31'h0, session_request_start}, 32'h1);
      repeat (8) @(posedge clock);
      rd(4'h4, 32'h100);
      rd(4'h0, 32'h000e_0002);
      wr(4'h0, 32'h0);
      wr(4'h4, 32'h100);
      answer_ok <= 1'b1;
      wr(4'h0, 32'h2);
      repeat (8) @(posedge clock);
      rd(4'h0, 32'h000e_0003);
      wr(4'h4, 32'h100);
      respond <= 1'b0;
      rd(4'h0, 32'h000e_0001);
      wr(4'h0, 32'h2);
      rd(4'h0, 32'h000e_0002);
      wr(4'h0, 32'h0);
      $display("test session request done");
   endtask
   task automatic t_host();
      device_mode <= 1'b0;
      pulse(3'h4);
      rd(4'h4, 32'h0);
      wr(4'h0, 32'h400);
      chk({31'h0, peer_negotiation_accept}, 32'h1);
      pulse(3'h4);
      rd(4'h4, 32'h2_0000);
      pulse(3'h2);
      rd(4'h4, 32'h6_0000);
      pulse(3'h1);
      rd(4'h4, 32'he_0000);
      wr(4'h0, 32'he02);
      rd(4'h0, 32'h000e_0400);
      wr(4'h4, 32'he_0000);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0, 2'h2);
      wr(4'hc, 32'h0, 2'h2);
      $display("test host done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // counts, verdict and end of run
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      end_of_test();
   end
   // reset, then the scenarios in turn
   initial begin
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      t_status();
      t_hnp();
      t_srp();
      t_host();
      end_of_test();
   end
endmodule
